// file: phy_vendor_mode_irq_regs.sv
// Purpose: Vendor mode, PLL/polarity, interrupt and link status regs
// Assumes: Events and status inputs come from logic on mclk
// Notes:   Reached over the serial management pins only
`timescale 1ns/1ps
`include "phy_regs_consts.svh"
module phy_vendor_mode_irq_regs
  import phy_regs_pkg::*;
#(
  parameter logic [2:0]  MODE_DEFAULT   = `MODE_RST,
  parameter logic [31:0] ENERGY_CYCLES  = `ENERGY_MS * 1000 * `CLK_MHZ
)
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       soft_reset,
  input  wire logic       mdc,
  input  wire logic       mdio_in,
  output logic            mdio_out,
  output logic            mdio_oe_n,
  input  wire logic       line_energy_seen,
  input  wire logic [6:1] irq_events,
  input  wire logic       rx_polarity_reversed,
  input  wire logic       autoneg_done,
  input  wire logic [2:0] resolved_speed_duplex,
  output logic            phy_irq,
  output logic [3:0]      ctl_defaults,
  output logic [3:0]      adv_defaults,
  output logic            crs_on_tx,
  output logic            repeater_mode,
  output logic            rx_pll_ref_lock,
  output logic            line_energy_present
);
  regs_st_t    st;
  regs_st_t    next_st;
  smi_regs_if  bus ();
  logic        rd_flags;
  logic [7:0]  set_flags;
  logic [15:0] rd_word;

  // ****************************************************************
  // Serial management frames
  // ****************************************************************
  smi_frame_engine u_engine (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .mdc       (mdc),
    .mdio_in   (mdio_in),
    .mdio_out  (mdio_out),
    .mdio_oe_n (mdio_oe_n),
    .bus       (bus.engine)
  );

  // engine compares frames against the stored address
  assign bus.station = st.addr;
  assign bus.rdata   = st.rdata;

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Unlisted indices and unused bits read as zero; the status reserved field reads back as stored
  always_comb
  begin
    rd_word = 16'h0000;
    case (bus.addr)
      `REG_MODE_ADDR:
      begin
        rd_word[`MODE_MSB:`MODE_LSB] = st.mode;
        rd_word[`ADDR_MSB:0]         = st.addr;
      end
      `REG_PLL_POL:
      begin
        rd_word[`PLL_BIT] = st.pll;
        rd_word[`POL_BIT] = rx_polarity_reversed;
        // fixed pattern, writes never reach it
        rd_word[`FIXED_MSB:0] = `CSR_FIXED;
      end
      `REG_IRQ_SRC:
        rd_word[7:0] = st.flags;
      `REG_IRQ_MASK:
        rd_word[7:0] = st.mask;
      `REG_LINK_STAT:
      begin
        rd_word[`AUTODONE_BIT] = autoneg_done;
        rd_word[`RSV_MSB:`RSV_LSB] = st.rsv;
        rd_word[`SPD_MSB:`SPD_LSB] = resolved_speed_duplex;
      end
      default:
        rd_word = 16'h0000;
    endcase
  end

  // ****************************************************************
  // Register state
  // ****************************************************************
  assign rd_flags = bus.rd && bus.addr == `REG_IRQ_SRC;

  // energy flag on a rise of the energy indication
  // flags 6:1 straight from the PHY event pulses, flag 0 always zero
  // Energy rise taken from the input so no loop runs through next_st
  assign set_flags = {line_energy_seen & ~st.energy, irq_events, 1'b0};

  // All state updates
  always_comb
  begin
    next_st = st;
    if (bus.rd)
      next_st.rdata = rd_word;
    // clear on read, but a new event in that cycle wins
    if (rd_flags)
      next_st.flags = 8'h00;
    if (bus.wr)
    begin
      case (bus.addr)
        `REG_MODE_ADDR:
        begin
          next_st.mode = bus.wdata[`MODE_MSB:`MODE_LSB];
          next_st.addr = bus.wdata[`ADDR_MSB:0];
        end
        `REG_PLL_POL:
          next_st.pll = bus.wdata[`PLL_BIT];
        `REG_IRQ_MASK:
          next_st.mask = bus.wdata[7:0];
        `REG_LINK_STAT:
          // kept as written, expected to be 0000010
          next_st.rsv = bus.wdata[`RSV_MSB:`RSV_LSB];
        default:
          next_st.rsv = next_st.rsv;
      endcase
    end
    // soft reset spares mode, address and PLL override
    if (soft_reset)
    begin
      next_st.mask  = 8'h00;
      next_st.flags = 8'h00;
      next_st.rsv   = `RSV_RST;
    end
    // quiet-line timeout, untouched by soft reset
    if (line_energy_seen)
    begin
      next_st.energy = 1'b1;
      next_st.ecnt   = 32'h0000_0000;
    end
    else if (st.energy)
    begin
      next_st.ecnt = st.ecnt + 32'h0000_0001;
      if (st.ecnt >= ENERGY_CYCLES - 32'h0000_0001)
      begin
        next_st.energy = 1'b0;
        next_st.ecnt   = 32'h0000_0000;
      end
    end
    next_st.flags = next_st.flags | set_flags;
    next_st.irq = |(next_st.flags & next_st.mask);
    next_st.crs_tx = 1'b0;
    next_st.rep    = 1'b0;
    next_st.adv    = 4'h0;
    case (next_st.mode)
      `MODE_10HD:
      begin
        next_st.ctl    = 4'h0;
        next_st.crs_tx = 1'b1;
      end
      `MODE_10FD:
        next_st.ctl = 4'h1;
      `MODE_100HD:
      begin
        next_st.ctl    = 4'h8;
        next_st.crs_tx = 1'b1;
      end
      `MODE_100FD:
        next_st.ctl = 4'h9;
      `MODE_AN_100HD:
      begin
        next_st.ctl    = 4'hC;
        next_st.adv    = 4'h4;
        next_st.crs_tx = 1'b1;
      end
      `MODE_REPEATER:
      begin
        next_st.ctl = 4'hC;
        next_st.adv = 4'h4;
        next_st.rep = 1'b1;
      end
      `MODE_ALL:
      begin
        next_st.ctl = 4'hD;
        next_st.adv = 4'hF;
      end
      default:
        next_st.ctl = 4'h0;
    endcase
  end

  // State register; only hardware reset reloads soft-reset-exempt fields
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      st        <= '0;
      st.mode   <= MODE_DEFAULT;
      st.addr   <= `ADDR_RST;
      st.rsv    <= `RSV_RST;
      st.energy <= 1'b1;
    end
    else
      st <= next_st;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // PLL held on reference while the override is set
  assign rx_pll_ref_lock     = st.pll;
  assign phy_irq             = st.irq;
  assign ctl_defaults        = st.ctl;
  assign adv_defaults        = st.adv;
  assign crs_on_tx           = st.crs_tx;
  assign repeater_mode       = st.rep;
  assign line_energy_present = st.energy;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_mode_wr4;
    bus.wr && bus.addr == `REG_MODE_ADDR && !soft_reset
      && bus.wdata[`MODE_MSB:`MODE_LSB] == `MODE_AN_100HD;
  endsequence

  sequence s_src_rd;
    bus.rd && bus.addr == `REG_IRQ_SRC;
  endsequence

  a_mode_write_dflt: assert property (
    s_mode_wr4 |=> st.mode == `MODE_AN_100HD ##0 ctl_defaults == 4'hC
      ##0 adv_defaults == 4'h4 ##0 crs_on_tx)
    else $error("mode 100 defaults wrong");

  a_exempt_keep_mode: assert property (
    soft_reset && !bus.wr |=> $stable(st.mode) && $stable(st.addr)
      && $stable(rx_pll_ref_lock))
    else $error("soft reset disturbed mode fields");

  a_flag_set_wins: assert property (
    s_src_rd ##0 irq_events[1] && !soft_reset |=> st.flags[1])
    else $error("event lost on read clear");

  a_flag_read_clears: assert property (
    s_src_rd ##0 (irq_events == 6'h00) && $stable(line_energy_present)
      |=> st.flags[6:1] == 6'h00)
    else $error("flags not cleared by read");

  a_irq_enabled_src: assert property (
    (|(irq_events & st.mask[6:1])) && !soft_reset && !bus.wr |=> phy_irq)
    else $error("enabled event raised no interrupt");

  a_irq_masked_off: assert property (
    st.mask == 8'h00 && !bus.wr ##1 st.mask == 8'h00 |-> !phy_irq)
    else $error("interrupt with all sources masked");

  a_fixed_bits_rd: assert property (
    bus.rd && bus.addr == `REG_PLL_POL |=> bus.rdata[3:0] == `CSR_FIXED
      && bus.rdata[`POL_BIT] == $past(rx_polarity_reversed))
    else $error("control/status fixed bits wrong");

  a_status_rd_path: assert property (
    bus.rd && bus.addr == `REG_LINK_STAT |=>
      bus.rdata[`SPD_MSB:`SPD_LSB] == $past(resolved_speed_duplex)
      && bus.rdata[`AUTODONE_BIT] == $past(autoneg_done))
    else $error("link status read wrong");

  a_energy_rise_flag: assert property (
    !line_energy_present ##1 line_energy_present |-> st.flags[7])
    else $error("energy rise did not set flag");

  a_energy_on_seen: assert property (
    line_energy_seen |=> line_energy_present ##0 st.ecnt == 32'h0)
    else $error("energy indication not set");
endmodule : phy_vendor_mode_irq_regs

// file: phy_regs_consts.svh
// Purpose: Offsets, field positions, reset values and timing figures
// Assumes: 5-bit management register index, 16-bit registers
// Notes:   Definitions only
`ifndef PHY_REGS_CONSTS_SVH
`define PHY_REGS_CONSTS_SVH
// ****************************************************************
// Register indices
// ****************************************************************
`define REG_MODE_ADDR  5'h12
`define REG_PLL_POL    5'h1B
`define REG_IRQ_SRC    5'h1D
`define REG_IRQ_MASK   5'h1E
`define REG_LINK_STAT  5'h1F
// ****************************************************************
// Fields and reset values
// ****************************************************************
`define MODE_MSB       7
`define MODE_LSB       5
`define ADDR_MSB       4
`define PLL_BIT        10
`define POL_BIT        4
`define FIXED_MSB      3
`define AUTODONE_BIT   12
`define RSV_MSB        11
`define RSV_LSB        5
`define SPD_MSB        4
`define SPD_LSB        2
`define ENERGY_FLAG    7
`define ADDR_RST       5'h01
`define MODE_RST       3'h7
`define CSR_FIXED      4'hB
`define RSV_RST        7'h02
// ****************************************************************
// Mode codes
// ****************************************************************
`define MODE_10HD      3'h0
`define MODE_10FD      3'h1
`define MODE_100HD     3'h2
`define MODE_100FD     3'h3
`define MODE_AN_100HD  3'h4
`define MODE_REPEATER  3'h5
`define MODE_ALL       3'h7
// ****************************************************************
// Frame and timing
// ****************************************************************
`define PRE_ONES       6'h20
`define HDR_LAST       6'h0C
`define WR_LAST        6'h11
`define RD_BITS        6'h10
`define OP_RD          2'h2
`define OP_WR          2'h1
`define ENERGY_MS      256
`define CLK_MHZ        100
`endif

// file: phy_regs_pkg.sv
// Purpose: Types shared by the management frame engine and registers
// Assumes: Nothing
// Notes:   Constants live in phy_regs_consts.svh
package phy_regs_pkg;
  typedef enum logic [2:0] {
    SMI_PRE  = 3'h0,
    SMI_HDR  = 3'h1,
    SMI_TA   = 3'h2,
    SMI_RD   = 3'h3,
    SMI_WR   = 3'h4
  } smi_state_t;

  typedef struct packed {
    logic        mdc_s1;
    logic        mdc_s2;
    logic        mdc_d;
    logic        io_s1;
    logic        io_s2;
    smi_state_t  state;
    logic [5:0]  cnt;
    logic [15:0] sh;
    logic        match;
    logic [4:0]  addr;
    logic        out;
    logic        oe_n;
    logic        rd;
    logic        wr;
  } smi_st_t;

  typedef struct packed {
    logic [2:0]  mode;
    logic [4:0]  addr;
    logic        pll;
    logic [7:0]  mask;
    logic [7:0]  flags;
    logic [6:0]  rsv;
    logic        energy;
    logic [31:0] ecnt;
    logic [15:0] rdata;
    logic        irq;
    logic [3:0]  ctl;
    logic [3:0]  adv;
    logic        crs_tx;
    logic        rep;
  } regs_st_t;
endpackage : phy_regs_pkg

// file: smi_regs_if.sv
// Purpose: Register request path from frame engine to register bank
// Assumes: Single clock mclk
// Notes:   rd and wr are one-cycle pulses
`timescale 1ns/1ps
interface smi_regs_if;
  logic        rd;
  logic        wr;
  logic [4:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [4:0]  station;
  modport engine (output rd, wr, addr, wdata, input rdata, station);
  modport regs   (input rd, wr, addr, wdata, output rdata, station);
endinterface : smi_regs_if

// file: smi_frame_engine.sv
// Purpose: Serial management frame slave (preamble, header, data)
// Assumes: mdc far slower than mclk; pins synchronised here
// Notes:   Drives data after each synchronised mdc rising edge
`timescale 1ns/1ps
`include "phy_regs_consts.svh"
module smi_frame_engine
  import phy_regs_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic mdc,
  input  wire logic mdio_in,
  output logic      mdio_out,
  output logic      mdio_oe_n,
  smi_regs_if.engine bus
);
  smi_st_t st;
  smi_st_t next_st;
  logic    rise;
  logic    bit_in;

  // Edge seen only on the second synchroniser stage
  assign rise   = st.mdc_s2 & ~st.mdc_d;
  assign bit_in = st.io_s2;

  // Frame decode
  always_comb
  begin
    next_st        = st;
    next_st.mdc_s1 = mdc;
    next_st.mdc_s2 = st.mdc_s1;
    next_st.mdc_d  = st.mdc_s2;
    next_st.io_s1  = mdio_in;
    next_st.io_s2  = st.io_s1;
    next_st.rd     = 1'b0;
    next_st.wr     = 1'b0;
    if (rise)
    begin
      case (st.state)
        SMI_PRE:
        begin
          // Any zero before a full preamble restarts the count
          if (bit_in)
            next_st.cnt = (st.cnt == `PRE_ONES) ? st.cnt : st.cnt + 6'h01;
          else if (st.cnt == `PRE_ONES)
          begin
            next_st.state = SMI_HDR;
            next_st.cnt   = 6'h00;
          end
          else
            next_st.cnt = 6'h00;
        end
        SMI_HDR:
        begin
          next_st.sh  = {st.sh[14:0], bit_in};
          next_st.cnt = st.cnt + 6'h01;
          if (st.cnt == `HDR_LAST)
          begin
            next_st.cnt   = 6'h00;
            next_st.addr  = next_st.sh[4:0];
            // answer only our own station address
            next_st.match = (next_st.sh[9:5] == bus.station);
            next_st.state = SMI_PRE;
            if (next_st.sh[12] && next_st.sh[11:10] == `OP_RD
                && next_st.match)
            begin
              next_st.rd    = 1'b1;
              next_st.state = SMI_TA;
            end
            else if (next_st.sh[12] && next_st.sh[11:10] == `OP_WR)
              next_st.state = SMI_WR;
          end
        end
        SMI_TA:
        begin
          next_st.oe_n  = 1'b0;
          next_st.out   = 1'b0;
          next_st.sh    = bus.rdata;
          next_st.state = SMI_RD;
        end
        SMI_RD:
        begin
          if (st.cnt == `RD_BITS)
          begin
            next_st.oe_n  = 1'b1;
            next_st.cnt   = 6'h00;
            next_st.state = SMI_PRE;
          end
          else
          begin
            next_st.out = st.sh[15];
            next_st.sh  = {st.sh[14:0], 1'b0};
            next_st.cnt = st.cnt + 6'h01;
          end
        end
        SMI_WR:
        begin
          // Two turnaround bits then sixteen data bits
          next_st.sh  = {st.sh[14:0], bit_in};
          next_st.cnt = st.cnt + 6'h01;
          if (st.cnt == `WR_LAST)
          begin
            next_st.wr    = st.match;
            next_st.cnt   = 6'h00;
            next_st.state = SMI_PRE;
          end
        end
        default:
          next_st.state = SMI_PRE;
      endcase
    end
  end

  // State register
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      st       <= '0;
      st.oe_n  <= 1'b1;
      st.state <= SMI_PRE;
    end
    else
      st <= next_st;
  end

  assign mdio_out  = st.out;
  assign mdio_oe_n = st.oe_n;
  assign bus.rd    = st.rd;
  assign bus.wr    = st.wr;
  assign bus.addr  = st.addr;
  assign bus.wdata = st.sh;
endmodule : smi_frame_engine

// file: smi_station_model.sv
// Purpose: Station manager model on the serial management pins
// Assumes: mdc period of 10 mclk, pins changed on falling mclk
// Notes:   A released line reads high through the pull-up
`timescale 1ns/1ps
module smi_station_model
(
  input  wire logic mclk,
  input  wire logic pin,
  output logic      mdc,
  output logic      drv,
  output logic      dval
);
  // ****************************************************************
  // Bit and frame tasks
  // ****************************************************************
  // Idle: clock stands low, line released
  initial
  begin
    mdc  = 1'b0;
    drv  = 1'b0;
    dval = 1'b1;
  end

  // One mdc period; sample just before the rise, as the device
  // launches its bits a few mclk after each rise
  task automatic bit_io(input logic b, input logic en, output logic s);
    drv  = en;
    dval = b;
    mdc  = 1'b0;
    repeat (5) @(negedge mclk);
    s   = pin;
    mdc = 1'b1;
    repeat (5) @(negedge mclk);
  endtask : bit_io

  // Preamble, start, opcode and both addresses
  task automatic header(input logic [1:0] op, input logic [4:0] phy,
                        input logic [4:0] ra);
    logic [45:0] hdr;
    logic        s;
    hdr = {32'hFFFFFFFF, 2'h1, op, phy, ra};
    for (int i = 45; i >= 0; i--)
      bit_io(hdr[i], 1'b1, s);
  endtask : header

  task automatic smi_write(input logic [4:0] phy, input logic [4:0] ra,
                           input logic [15:0] data);
    logic [17:0] tail;
    logic        s;
    if (ra == 5'h1F)
      data[11:5] = 7'h02;
    tail = {2'h2, data};
    header(2'h1, phy, ra);
    for (int i = 17; i >= 0; i--)
      bit_io(tail[i], 1'b1, s);
    bit_io(1'b1, 1'b0, s);
  endtask : smi_write

  // Turnaround, sixteen data bits, then one bit for the release
  task automatic smi_read(input logic [4:0] phy, input logic [4:0] ra,
                          output logic ta, output logic [15:0] data);
    logic s;
    header(2'h2, phy, ra);
    bit_io(1'b1, 1'b0, s);
    bit_io(1'b1, 1'b0, ta);
    for (int i = 15; i >= 0; i--)
    begin
      bit_io(1'b1, 1'b0, s);
      data[i] = s;
    end
    bit_io(1'b1, 1'b0, s);
  endtask : smi_read
endmodule : smi_station_model

// file: testbench.sv
// Purpose: Self-checking bench for the vendor register group
// Assumes: Energy timeout shortened to 16 cycles
// Notes:   Random stimulus from a fixed seed
`timescale 1ns/1ps
`include "phy_regs_consts.svh"
module testbench;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        soft_reset = 1'b0;
  logic        seen = 1'b0;
  logic [6:1]  ev_in = 6'h00;
  logic        pol = 1'b0;
  logic        an = 1'b0;
  logic [2:0]  spd = 3'h1;
  logic        mdio_out, mdio_oe_n, phy_irq, crs_on_tx, repeater_mode;
  logic        rx_pll_ref_lock, line_energy_present, mdc, drv, dval;
  logic [3:0]  ctl_defaults, adv_defaults;
  logic [4:0]  station = `ADDR_RST;
  logic [4:0]  na;
  logic [2:0]  mv;
  logic [7:0]  mk;
  logic [6:1]  ev;
  logic [15:0] xs;
  logic [15:0] d;
  logic        ta;
  int          err_count = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          seed;
  // Wire level: device, else manager, else pull-up
  wire pin = !mdio_oe_n ? mdio_out : (drv ? dval : 1'b1);

  phy_vendor_mode_irq_regs #(.ENERGY_CYCLES(32'h0000_0010)) dut (
    .mclk(mclk), .rst_n(rst_n), .soft_reset(soft_reset), .mdc(mdc),
    .mdio_in(pin), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
    .line_energy_seen(seen), .irq_events(ev_in),
    .rx_polarity_reversed(pol), .autoneg_done(an),
    .resolved_speed_duplex(spd), .phy_irq(phy_irq),
    .ctl_defaults(ctl_defaults), .adv_defaults(adv_defaults),
    .crs_on_tx(crs_on_tx), .repeater_mode(repeater_mode),
    .rx_pll_ref_lock(rx_pll_ref_lock),
    .line_energy_present(line_energy_present));

  smi_station_model mgr (.mclk(mclk), .pin(pin), .mdc(mdc), .drv(drv),
                         .dval(dval));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  always #5 mclk = ~mclk;

  // Hang guard, well above the expected run length
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      err_count++;
      stop_test();
    end
  end

  // Expected {repeater, crs_on_tx, adv, ctl} for a mode
  function automatic logic [9:0] mode_exp(input logic [2:0] m);
    case (m)
      3'h0:    mode_exp = 10'h100;
      3'h1:    mode_exp = 10'h001;
      3'h2:    mode_exp = 10'h108;
      3'h3:    mode_exp = 10'h009;
      3'h4:    mode_exp = 10'h14C;
      3'h5:    mode_exp = 10'h24C;
      default: mode_exp = 10'h0FD;
    endcase
  endfunction : mode_exp

  task automatic chk(input string nm, input logic [15:0] seen_v,
                     input logic [15:0] exp);
    total_checks++;
    if (seen_v !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen_v);
    end
  endtask : chk

  task automatic rdreg(input logic [4:0] ra, input logic [15:0] exp,
                       input logic [15:0] msk, input string nm);
    mgr.smi_read(station, ra, ta, d);
    chk("turnaround", {15'h0, ta}, 16'h0000);
    chk(nm, d & msk, exp);
  endtask : rdreg

  task automatic wrreg(input logic [4:0] ra, input logic [15:0] v);
    mgr.smi_write(station, ra, v);
  endtask : wrreg

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    seed = $urandom(55160);
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    chk("energy_rst", {15'h0, line_energy_present}, 16'h0001);
    chk("oe_idle", {15'h0, mdio_oe_n}, 16'h0001);
    chk("outs_rst", {6'h0, repeater_mode, crs_on_tx, adv_defaults,
        ctl_defaults}, {6'h0, mode_exp(3'h7)});
    rdreg(`REG_MODE_ADDR, 16'h00E1, 16'hFFFF, "mode_rst");
    rdreg(`REG_PLL_POL, 16'h000B, 16'hFFFF, "pll_rst");
    rdreg(`REG_IRQ_SRC, 16'h0000, 16'hFFFF, "flags_rst");
    rdreg(`REG_IRQ_MASK, 16'h0000, 16'hFFFF, "mask_rst");
    rdreg(5'h05, 16'h0000, 16'hFFFF, "unmapped");
    $display("test reset done");

    for (int m = 0; m < 8; m++)
    begin
      mv = m[2:0];
      if (m == 6)
        continue;
      wrreg(`REG_MODE_ADDR, {8'($urandom), mv, station});
      chk("mode_outs", {6'h0, repeater_mode, crs_on_tx, adv_defaults,
          ctl_defaults}, {6'h0, mode_exp(mv)});
      rdreg(`REG_MODE_ADDR, {8'h00, mv, station}, 16'hFFFF, "mode");
    end
    $display("test modes done");

    na = 5'($urandom_range(2, 31));
    wrreg(`REG_MODE_ADDR, {8'h00, 3'h3, na});
    mgr.smi_read(station, `REG_MODE_ADDR, ta, d);
    chk("old_addr", d, 16'hFFFF);
    station = na;
    rdreg(`REG_MODE_ADDR, {8'h00, 3'h3, na}, 16'hFFFF, "new_addr");
    $display("test address done");

    pol = 1'b1;
    wrreg(`REG_PLL_POL, 16'($urandom) | 16'h0400);
    wrreg(`REG_IRQ_MASK, 16'h00FF);
    chk("pll_out", {15'h0, rx_pll_ref_lock}, 16'h0001);
    rdreg(`REG_PLL_POL, 16'h041B, 16'h041F, "pll");
    soft_reset = 1'b1;
    @(negedge mclk);
    soft_reset = 1'b0;
    rdreg(`REG_MODE_ADDR, {8'h00, 3'h3, na}, 16'hFFFF, "soft_mode");
    rdreg(`REG_PLL_POL, 16'h041B, 16'h041F, "soft_pll");
    rdreg(`REG_IRQ_MASK, 16'h0000, 16'hFFFF, "soft_mask");
    wrreg(`REG_PLL_POL, 16'h0000);
    chk("pll_off", {15'h0, rx_pll_ref_lock}, 16'h0000);
    $display("test soft reset done");

    // First round raises all six event sources at once as a corner case
    for (int k = 0; k < 4; k++)
    begin
      mk = 8'($urandom);
      wrreg(`REG_IRQ_MASK, {8'h00, mk});
      rdreg(`REG_IRQ_MASK, {8'h00, mk}, 16'hFFFF, "mask");
      @(negedge mclk);
      ev = (k == 0) ? 6'h3F : 6'($urandom);
      ev_in = ev;
      @(negedge mclk);
      ev_in = 6'h00;
      @(negedge mclk);
      chk("irq", {15'h0, phy_irq}, {15'h0, |({ev, 1'b0} & mk)});
      rdreg(`REG_IRQ_SRC, {8'h00, ev, 1'b0}, 16'hFFFF, "flags");
      chk("irq_clr", {15'h0, phy_irq}, 16'h0000);
    end
    $display("test irq done");

    // Status word, then a fresh energy rise and its quiet timeout
    an = 1'b1;
    spd = ($urandom % 2) ? 3'h6 : 3'h5;
    xs = {3'h0, an, 7'h02, spd, 2'h0};
    wrreg(`REG_LINK_STAT, 16'($urandom));
    rdreg(`REG_LINK_STAT, xs, 16'hFFFF, "status");
    chk("energy_quiet", {15'h0, line_energy_present}, 16'h0000);
    seen = 1'b1;
    @(negedge mclk);
    seen = 1'b0;
    @(negedge mclk);
    chk("energy_on", {15'h0, line_energy_present}, 16'h0001);
    repeat (16) @(negedge mclk);
    chk("energy_off", {15'h0, line_energy_present}, 16'h0000);
    rdreg(`REG_IRQ_SRC, 16'h0080, 16'hFFFF, "energy_flag");
    $display("test status and energy done");

    // Only a hardware reset reloads mode and address
    rst_n = 1'b0;
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    chk("energy_hard", {15'h0, line_energy_present}, 16'h0001);
    station = `ADDR_RST;
    rdreg(`REG_MODE_ADDR, 16'h00E1, 16'hFFFF, "hard_mode");
    rdreg(`REG_PLL_POL, 16'h001B, 16'hFFFF, "hard_pll");
    $display("test hard reset done");
    stop_test();
  end
endmodule : testbench
